//--- rtl/sacc_defines.svh
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define SACC_OFS_CTRL        8'h00
`define SACC_OFS_CFG         8'h04
`define SACC_OFS_RES_HIGH    8'h08
`define SACC_OFS_RES_LOW     8'h0C
`define SACC_OFS_POS_MUX     8'h10

// Control register fields.
`define SACC_CTRL_ENABLE     7
`define SACC_CTRL_LP_TRACK   6
`define SACC_CTRL_DONE       5
`define SACC_CTRL_BUSY       4
`define SACC_CTRL_SRC_HI     2
`define SACC_CTRL_SRC_LO     0

// Configuration register fields.
`define SACC_CFG_DIV_HI      7
`define SACC_CFG_DIV_LO      3
`define SACC_CFG_LJST        2

// Positive mux register fields.
`define SACC_MUX_DIFF        6
`define SACC_MUX_SEL_HI      5
`define SACC_MUX_SEL_LO      0

// Reset values.
`define SACC_CTRL_RESET      8'h00
`define SACC_DIV_RESET       5'h1F
`define SACC_LJST_RESET      1'b1
`define SACC_MUX_SEL_RESET   6'h00

// Input select code that routes the temperature sensor.
`define SACC_TEMP_SENSOR_SEL 6'h1E

// Low-power track length in SAR clocks, result width and code constants.
`define SACC_LP_TRACK_CLKS   2'd3
`define SACC_RESULT_BITS     10
`define SACC_TRIAL_FIRST     10'h200
`define SACC_SIGN_FLIP       10'h200

`endif

//--- rtl/sacc_pkg.sv
package sacc_pkg;

    typedef enum logic [1:0] {
        SACC_ST_IDLE    = 2'b00,
        SACC_ST_TRACK   = 2'b01,
        SACC_ST_CONVERT = 2'b10
    } sacc_state_t;

    typedef enum logic [2:0] {
        SACC_SRC_BUSY_WRITE = 3'b000,
        SACC_SRC_TIMER0     = 3'b001,
        SACC_SRC_TIMER2     = 3'b010,
        SACC_SRC_TIMER1     = 3'b011,
        SACC_SRC_EXT_START  = 3'b100,
        SACC_SRC_TIMER3     = 3'b101,
        SACC_SRC_TIMER4     = 3'b110,
        SACC_SRC_TIMER5     = 3'b111
    } sacc_src_t;

endpackage

//--- rtl/sacc_fmt.sv
`timescale 1ns/1ns
`include "sacc_defines.svh"

module sacc_fmt (
    // Raw successive-approximation code, offset binary.
    input  wire logic [9:0] code,
    // Formatting controls.
    input  wire logic       diff_mode,
    input  wire logic       left_justify,
    // Formatted byte pair.
    output logic      [7:0] res_high,
    output logic      [7:0] res_low
);
    logic [9:0]  value;
    logic [15:0] word;

    always_comb begin
        value = code;
        if (diff_mode) begin
            value = code ^ `SACC_SIGN_FLIP;
        end
        if (left_justify) begin
            word = {value, 6'b00_0000};
        end else if (diff_mode) begin
            word = {{6{value[9]}}, value};
        end else begin
            word = {6'b00_0000, value};
        end
    end

    assign res_high = word[15:8];
    assign res_low  = word[7:0];
endmodule

//--- rtl/sacc_top.sv
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "sacc_defines.svh"

module sacc_top (
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // Avalon-MM register slave.
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Start sources: one-cycle timer overflow pulses, timer counting modes and the external start level.
    input  wire logic        TMR0_OVF,
    input  wire logic        TMR1_OVF,
    input  wire logic [3:0]  TMR_LO_OVF,
    input  wire logic [3:0]  TMR_HI_OVF,
    input  wire logic [3:0]  TMR_8BIT_MODE,
    input  wire logic        EXT_START,
    // System power state and interrupt enable.
    input  wire logic        STANDBY,
    input  wire logic        IRQ_ENABLE,
    // Analog converter core.
    input  wire logic        SAR_CMP,
    output logic      [9:0]  SAR_TRIAL,
    output logic             ADC_POWER_EN,
    output logic             TRACK_EN,
    output logic             DIFF_MODE,
    output logic      [5:0]  POS_INPUT_SEL,
    output logic             TEMP_SENSOR_ROUTE,
    output logic             CONV_DONE_IRQ
);
    import sacc_pkg::*;

    // Bus handshake state.
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Software-visible registers.
    logic        enable_reg;
    logic        enable_next;
    logic        lp_track_reg;
    logic        lp_track_next;
    logic        done_reg;
    logic        done_next;
    logic        busy_reg;
    logic        busy_next;
    sacc_src_t   src_reg;
    sacc_src_t   src_next;
    logic [4:0]  div_reg;
    logic [4:0]  div_next;
    logic        ljst_reg;
    logic        ljst_next;
    logic        diff_reg;
    logic        diff_next;
    logic [5:0]  sel_reg;
    logic [5:0]  sel_next;
    logic [7:0]  res_high_reg;
    logic [7:0]  res_high_next;
    logic [7:0]  res_low_reg;
    logic [7:0]  res_low_next;

    // Sequencer state.
    sacc_state_t state_reg;
    sacc_state_t state_next;
    logic [4:0]  tick_cnt_reg;
    logic [4:0]  tick_cnt_next;
    logic [1:0]  track_cnt_reg;
    logic [1:0]  track_cnt_next;
    logic [3:0]  bit_reg;
    logic [3:0]  bit_next;
    logic [9:0]  trial_reg;
    logic [9:0]  trial_next;
    logic        ext_prev_reg;
    logic        track_reg;
    logic        track_next;

    // Combinational helpers.
    logic        wr_fire;
    logic        sw_busy_write;
    logic        ext_rise;
    logic        start_event;
    logic        sar_tick;
    logic [7:0]  ctrl_value;
    logic [7:0]  fmt_high;
    logic [7:0]  fmt_low;

    // Overflow of timer 2..5 picked by its counting mode.
    function automatic logic timer_ovf(input logic [1:0] idx);
        return TMR_8BIT_MODE[idx] ? TMR_LO_OVF[idx] : TMR_HI_OVF[idx];
    endfunction

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign AVS_READDATA    = rdata_reg;
    assign wr_fire         = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];

    assign ctrl_value = {enable_reg, lp_track_reg, done_reg, busy_reg, 1'b0, src_reg};

    always_comb begin
        ack_next   = (AVS_READ | AVS_WRITE) & ~ack_reg;
        rdata_next = rdata_reg;
        if (AVS_READ & ~ack_reg) begin
            rdata_next = 32'h0000_0000;
            if (AVS_ADDRESS == `SACC_OFS_CTRL) begin
                rdata_next[7:0] = ctrl_value;
            end else if (AVS_ADDRESS == `SACC_OFS_CFG) begin
                rdata_next[7:0] = {div_reg, ljst_reg, 2'b00};
            end else if (AVS_ADDRESS == `SACC_OFS_RES_HIGH) begin
                rdata_next[7:0] = res_high_reg;
            end else if (AVS_ADDRESS == `SACC_OFS_RES_LOW) begin
                rdata_next[7:0] = res_low_reg;
            end else if (AVS_ADDRESS == `SACC_OFS_POS_MUX) begin
                rdata_next[7:0] = {1'b0, diff_reg, sel_reg};
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign sw_busy_write = wr_fire && (AVS_ADDRESS == `SACC_OFS_CTRL)
                           && AVS_WRITEDATA[`SACC_CTRL_BUSY];
    assign ext_rise      = EXT_START & ~ext_prev_reg;

    always_comb begin
        case (src_reg)
            SACC_SRC_BUSY_WRITE: start_event = sw_busy_write;
            SACC_SRC_TIMER0:     start_event = TMR0_OVF;
            SACC_SRC_TIMER2:     start_event = timer_ovf(2'd0);
            SACC_SRC_TIMER1:     start_event = TMR1_OVF;
            SACC_SRC_EXT_START:  start_event = ext_rise;
            SACC_SRC_TIMER3:     start_event = timer_ovf(2'd1);
            SACC_SRC_TIMER4:     start_event = timer_ovf(2'd2);
            default:             start_event = timer_ovf(2'd3);
        endcase
    end

    assign sar_tick = (tick_cnt_reg == div_reg);

    sacc_fmt u_fmt (
        .code         ({trial_reg[9:1], trial_reg[0] & SAR_CMP}),
        .diff_mode    (diff_reg),
        .left_justify (ljst_reg),
        .res_high     (fmt_high),
        .res_low      (fmt_low)
    );

    always_comb begin
        enable_next    = enable_reg;
        lp_track_next  = lp_track_reg;
        done_next      = done_reg;
        busy_next      = busy_reg;
        src_next       = src_reg;
        div_next       = div_reg;
        ljst_next      = ljst_reg;
        diff_next      = diff_reg;
        sel_next       = sel_reg;
        res_high_next  = res_high_reg;
        res_low_next   = res_low_reg;
        state_next     = state_reg;
        track_cnt_next = track_cnt_reg;
        bit_next       = bit_reg;
        trial_next     = trial_reg;
        tick_cnt_next  = sar_tick ? 5'd0 : tick_cnt_reg + 5'd1;

        if (wr_fire) begin
            if (AVS_ADDRESS == `SACC_OFS_CTRL) begin
                enable_next   = AVS_WRITEDATA[`SACC_CTRL_ENABLE];
                lp_track_next = AVS_WRITEDATA[`SACC_CTRL_LP_TRACK];
                done_next     = AVS_WRITEDATA[`SACC_CTRL_DONE];
                src_next      = sacc_src_t'(AVS_WRITEDATA[`SACC_CTRL_SRC_HI:`SACC_CTRL_SRC_LO]);
            end else if (AVS_ADDRESS == `SACC_OFS_CFG) begin
                div_next  = AVS_WRITEDATA[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
                ljst_next = AVS_WRITEDATA[`SACC_CFG_LJST];
            end else if (AVS_ADDRESS == `SACC_OFS_POS_MUX) begin
                diff_next = AVS_WRITEDATA[`SACC_MUX_DIFF];
                sel_next  = AVS_WRITEDATA[`SACC_MUX_SEL_HI:`SACC_MUX_SEL_LO];
            end
        end

        case (state_reg)
            SACC_ST_IDLE: begin
                if (start_event) begin
                    busy_next     = 1'b1;
                    tick_cnt_next = 5'd0;
                    if (lp_track_reg && (src_reg != SACC_SRC_EXT_START)) begin
                        state_next     = SACC_ST_TRACK;
                        track_cnt_next = 2'd0;
                    end else begin
                        state_next = SACC_ST_CONVERT;
                        bit_next   = 4'd9;
                        trial_next = `SACC_TRIAL_FIRST;
                    end
                end
            end
            SACC_ST_TRACK: begin
                if (sar_tick) begin
                    track_cnt_next = track_cnt_reg + 2'd1;
                    if (track_cnt_reg == `SACC_LP_TRACK_CLKS - 2'd1) begin
                        state_next = SACC_ST_CONVERT;
                        bit_next   = 4'd9;
                        trial_next = `SACC_TRIAL_FIRST;
                    end
                end
            end
            SACC_ST_CONVERT: begin
                if (sar_tick) begin
                    if (!SAR_CMP) begin
                        trial_next[bit_reg] = 1'b0;
                    end
                    if (bit_reg != 4'd0) begin
                        trial_next[bit_reg - 4'd1] = 1'b1;
                        bit_next = bit_reg - 4'd1;
                    end else begin
                        res_high_next = fmt_high;
                        res_low_next  = fmt_low;
                        busy_next     = 1'b0;
                        done_next     = 1'b1;
                        state_next    = SACC_ST_IDLE;
                    end
                end
            end
            default: state_next = SACC_ST_IDLE;
        endcase

        if (!enable_reg) begin
            state_next = SACC_ST_IDLE;
            busy_next  = 1'b0;
            if (wr_fire && (AVS_ADDRESS == `SACC_OFS_CTRL)) begin
                done_next = AVS_WRITEDATA[`SACC_CTRL_DONE];
            end else begin
                done_next = done_reg;
            end
        end

        track_next = enable_next && (state_next == SACC_ST_TRACK
                     || (state_next == SACC_ST_IDLE && !lp_track_next));
        if (enable_next && state_next == SACC_ST_IDLE && lp_track_next
            && src_next == SACC_SRC_EXT_START && !EXT_START) begin
            track_next = 1'b1;
        end
        if (STANDBY) begin
            track_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            enable_reg    <= 1'b0;
            lp_track_reg  <= 1'b0;
            done_reg      <= 1'b0;
            busy_reg      <= 1'b0;
            src_reg       <= SACC_SRC_BUSY_WRITE;
            div_reg       <= `SACC_DIV_RESET;
            ljst_reg      <= `SACC_LJST_RESET;
            diff_reg      <= 1'b0;
            sel_reg       <= `SACC_MUX_SEL_RESET;
            res_high_reg  <= 8'h00;
            res_low_reg   <= 8'h00;
            state_reg     <= SACC_ST_IDLE;
            tick_cnt_reg  <= 5'd0;
            track_cnt_reg <= 2'd0;
            bit_reg       <= 4'd0;
            trial_reg     <= 10'h000;
            ext_prev_reg  <= 1'b0;
            track_reg     <= 1'b0;
        end else begin
            enable_reg    <= enable_next;
            lp_track_reg  <= lp_track_next;
            done_reg      <= done_next;
            busy_reg      <= busy_next;
            src_reg       <= src_next;
            div_reg       <= div_next;
            ljst_reg      <= ljst_next;
            diff_reg      <= diff_next;
            sel_reg       <= sel_next;
            res_high_reg  <= res_high_next;
            res_low_reg   <= res_low_next;
            state_reg     <= state_next;
            tick_cnt_reg  <= tick_cnt_next;
            track_cnt_reg <= track_cnt_next;
            bit_reg       <= bit_next;
            trial_reg     <= trial_next;
            ext_prev_reg  <= EXT_START;
            track_reg     <= track_next;
        end
    end

    assign SAR_TRIAL         = trial_reg;
    assign ADC_POWER_EN      = enable_reg;
    assign TRACK_EN          = track_reg;
    assign DIFF_MODE         = diff_reg;
    assign POS_INPUT_SEL     = sel_reg;
    assign TEMP_SENSOR_ROUTE = (sel_reg == `SACC_TEMP_SENSOR_SEL);
    assign CONV_DONE_IRQ     = done_reg & IRQ_ENABLE;
endmodule

//--- tb/sacc_properties.sv
`timescale 1ns/1ns
module sacc_checker (
    // Clock and reset.
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    // Register bus.
    input wire logic [7:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // Converter side.
    input wire logic        STANDBY,
    input wire logic        IRQ_ENABLE,
    input wire logic        ADC_POWER_EN,
    input wire logic        TRACK_EN,
    input wire logic        DIFF_MODE,
    input wire logic [5:0]  POS_INPUT_SEL,
    input wire logic        TEMP_SENSOR_ROUTE,
    input wire logic        CONV_DONE_IRQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    wire take = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    wire wr_ctrl = take && AVS_ADDRESS == 8'h00;
    wire wr_mux = take && AVS_ADDRESS == 8'h10;
    sequence s_new_req;
        (AVS_READ || AVS_WRITE) && !$past(AVS_READ) && !$past(AVS_WRITE);
    endsequence
    sequence s_answer;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    chk_bus_answer: assert property (s_new_req |-> s_answer)
        else $error("register access not answered on its second cycle");
    chk_temp_route: assert property (TEMP_SENSOR_ROUTE == (POS_INPUT_SEL == 6'h1E))
        else $error("sensor routing does not follow the input select");
    chk_irq_gate: assert property (!IRQ_ENABLE |-> !CONV_DONE_IRQ)
        else $error("interrupt raised while disabled");
    chk_standby_track: assert property (STANDBY |=> !TRACK_EN)
        else $error("tracking kept on in standby");
    chk_off_track: assert property (!ADC_POWER_EN |-> !TRACK_EN)
        else $error("tracking while converter is off");
    chk_power_write: assert property ($changed(ADC_POWER_EN) |-> $past(wr_ctrl))
        else $error("enable changed without a control write");
    chk_mux_write: assert property ($changed(POS_INPUT_SEL) || $changed(DIFF_MODE)
        |-> $past(wr_mux))
        else $error("input select changed without a mux write");
    chk_done_hold: assert property (CONV_DONE_IRQ && !wr_ctrl ##1 IRQ_ENABLE |-> CONV_DONE_IRQ)
        else $error("done flag dropped without software clear");
    chk_done_power: assert property ($rose(CONV_DONE_IRQ) && $past(IRQ_ENABLE)
        && !$past(wr_ctrl) |-> $past(ADC_POWER_EN))
        else $error("conversion finished while converter was off");
    chk_rdata_upper: assert property (AVS_READDATA[31:8] == '0)
        else $error("upper read data bits not zero");
endmodule

bind sacc_top sacc_checker u_sacc_checker (.SYS_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .STANDBY, .IRQ_ENABLE, .ADC_POWER_EN,
    .TRACK_EN, .DIFF_MODE, .POS_INPUT_SEL, .TEMP_SENSOR_ROUTE, .CONV_DONE_IRQ);

//--- tb/sacc_analog_model.sv
`timescale 1ns/1ns
module sacc_analog_model (
    input  wire logic       clk,
    input  wire logic       power_en,
    input  wire logic       temp_route,
    input  wire logic [9:0] trial,
    input  wire logic [9:0] input_code,
    input  wire logic [9:0] temp_code,
    output logic            cmp
);
    logic flip_reg = 1'b0;
    always_ff @(posedge clk) flip_reg <= !flip_reg;
    // With temp_route set, the sensor drives input.
    // A powered-down comparator gives no steady answer.
    assign cmp = power_en ? (trial <= (temp_route ? temp_code : input_code)) : flip_reg;
endmodule

//--- tb/sacc_top_bench.sv
`timescale 1ns/1ns
module sacc_top_bench;
    import sacc_pkg::*;
    localparam logic [9:0] TEMP_CODE = 10'h2A5;
    logic        SYS_CLK, NRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, TMR0_OVF, TMR1_OVF;
    logic        EXT_START, STANDBY, IRQ_ENABLE, SAR_CMP, ADC_POWER_EN, TRACK_EN, DIFF_MODE;
    logic        TEMP_SENSOR_ROUTE, CONV_DONE_IRQ;
    logic [7:0]  AVS_ADDRESS, me, mm;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, seed;
    logic [3:0]  AVS_BYTEENABLE, TMR_LO_OVF, TMR_HI_OVF, TMR_8BIT_MODE, be;
    logic [9:0]  SAR_TRIAL, level;
    logic [5:0]  POS_INPUT_SEL;
    logic [7:0]  exp_q[$], mask_q[$];
    int          n_errors, checks_done, n_cyc, t0;
    sacc_top u_sacc_top (.SYS_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .TMR0_OVF, .TMR1_OVF, .TMR_LO_OVF,
        .TMR_HI_OVF, .TMR_8BIT_MODE, .EXT_START, .STANDBY, .IRQ_ENABLE, .SAR_CMP, .SAR_TRIAL,
        .ADC_POWER_EN, .TRACK_EN, .DIFF_MODE, .POS_INPUT_SEL, .TEMP_SENSOR_ROUTE, .CONV_DONE_IRQ);
    sacc_analog_model u_sacc_analog_model (.clk(SYS_CLK), .power_en(ADC_POWER_EN),
        .temp_route(TEMP_SENSOR_ROUTE), .trial(SAR_TRIAL), .input_code(level),
        .temp_code(TEMP_CODE), .cmp(SAR_CMP));
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] fmt(logic [9:0] c, logic d, logic lj);
        logic [9:0] v;
        v = d ? c ^ 10'h200 : c;
        if (lj) return {v, 6'h00};
        return {{6{d & v[9]}}, v};
    endfunction
    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    // Read completions are compared against the oldest expectation.
    always @(negedge SYS_CLK) begin
        if (AVS_READ && !AVS_WAITREQUEST && exp_q.size() > 0) begin
            me = exp_q.pop_front();
            mm = mask_q.pop_front();
            chk((AVS_READDATA & {24'hFF_FFFF, mm}) === {24'h00_0000, me & mm}, "read data");
        end
    end
    task automatic bus(input logic wr, input logic [7:0] a, d, m, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h00_0000, d};
        AVS_BYTEENABLE <= be;
        if (!wr) begin
            exp_q.push_back(d);
            mask_q.push_back(m);
        end
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (AVS_WAITREQUEST && n < 50);
        if (n >= 50) chk(1'b0, "bus hang");
        rd = AVS_READDATA[7:0];
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] r;
        bus(1'b1, a, d, 8'h00, r);
    endtask
    task automatic rdc(input logic [7:0] a, e, m);
        logic [7:0] r;
        bus(1'b0, a, e, m, r);
    endtask
    // Pulses the selected start source, or with alt a source that must not start it.
    task automatic fire(input logic [2:0] s, input logic alt, lp);
        logic [3:0] t;
        t = {s == SACC_SRC_TIMER5, s == SACC_SRC_TIMER4, s == SACC_SRC_TIMER3, s == SACC_SRC_TIMER2};
        if (s == SACC_SRC_BUSY_WRITE && !alt) begin
            wr(8'h00, {1'b1, lp, 3'b010, s});
            return;
        end
        @(posedge SYS_CLK);
        TMR0_OVF <= alt ? (s != SACC_SRC_TIMER0) : (s == SACC_SRC_TIMER0);
        TMR1_OVF <= alt ? (s == SACC_SRC_TIMER0) : (s == SACC_SRC_TIMER1);
        TMR_LO_OVF <= t & (alt ? ~TMR_8BIT_MODE : TMR_8BIT_MODE);
        TMR_HI_OVF <= t & (alt ? TMR_8BIT_MODE : ~TMR_8BIT_MODE);
        EXT_START <= !alt && s == SACC_SRC_EXT_START;
        @(posedge SYS_CLK);
        TMR0_OVF <= 1'b0;
        TMR1_OVF <= 1'b0;
        TMR_LO_OVF <= 4'h0;
        TMR_HI_OVF <= 4'h0;
    endtask
    task automatic conv(input logic [2:0] s, input logic lp, d, lj, input logic [4:0] dv,
                        input logic [5:0] sel, input logic [9:0] c);
        logic [15:0] f;
        level <= c;
        wr(8'h10, {1'b0, d, sel});
        wr(8'h04, {dv, lj, 2'b00});
        wr(8'h00, {1'b1, lp, 3'b000, s});
        fire(s, 1'b1, lp);
        chk(ADC_POWER_EN === 1'b1 && DIFF_MODE === d && POS_INPUT_SEL === sel, "settings");
        rdc(8'h00, 8'h00, 8'h30);
        chk(TRACK_EN === (!lp || s == SACC_SRC_EXT_START), "idle tracking");
        fire(s, 1'b0, lp);
        n_cyc = 0;
        while (CONV_DONE_IRQ !== 1'b1 && n_cyc < 2000) begin
            @(negedge SYS_CLK);
            n_cyc++;
            if (n_cyc == 2 && !lp) chk(TRACK_EN === 1'b0, "tracking while converting");
        end
        rdc(8'h00, 8'h20, 8'h30);
        f = fmt(sel == 6'h1E ? TEMP_CODE : c, d, lj);
        rdc(8'h08, f[15:8], 8'hFF);
        rdc(8'h0C, f[7:0], 8'hFF);
        wr(8'h00, {1'b1, lp, 3'b000, s});
    endtask
    initial begin
        {NRST, AVS_READ, AVS_WRITE, TMR0_OVF, TMR1_OVF, EXT_START, STANDBY} = '0;
        {AVS_ADDRESS, AVS_WRITEDATA, TMR_LO_OVF, TMR_HI_OVF, TMR_8BIT_MODE, level} = '0;
        {n_errors, checks_done} = '0;
        IRQ_ENABLE = 1'b1;
        AVS_BYTEENABLE = 4'h1;
        be = 4'h1;
        seed = 32'h0000_003A;
        repeat (10) @(posedge SYS_CLK);
        NRST <= 1'b1;
        foreach (exp_q[i]) exp_q.delete();
        rdc(8'h00, 8'h00, 8'hFF);
        rdc(8'h04, 8'hFC, 8'hFF);
        for (int a = 8; a <= 20; a += 4) rdc(a[7:0], 8'h00, 8'hFF);
        wr(8'h00, 8'h10);
        rdc(8'h00, 8'h00, 8'hFF);
        be = 4'hE;
        wr(8'h10, 8'h1E);
        be = 4'h1;
        wr(8'h08, 8'hFF);
        rdc(8'h10, 8'h00, 8'hFF);
        rdc(8'h08, 8'h00, 8'hFF);
        for (int i = 0; i < 20; i++)
            conv(SACC_SRC_BUSY_WRITE, 1'b0, i[0], i[1], 5'h01, 6'h00,
                 10'h3FF - 10'(i / 4) * 10'h100);
        for (int i = 2; i < 16; i++) begin
            TMR_8BIT_MODE <= 4'(rnd());
            conv(i[2:0] + 3'h1, i[3], 1'(rnd()), 1'(rnd()), 5'h01, 6'h00, 10'(rnd()));
        end
        conv(SACC_SRC_BUSY_WRITE, 1'b0, 1'b0, 1'b0, 5'h01, 6'h1E, 10'h001);
        t0 = n_cyc;
        conv(SACC_SRC_BUSY_WRITE, 1'b1, 1'b0, 1'b0, 5'h01, 6'h00, 10'h155);
        chk(n_cyc - t0 == 6, "low-power track length");
        conv(SACC_SRC_BUSY_WRITE, 1'b0, 1'b0, 1'b0, 5'h03, 6'h00, 10'h2AA);
        chk(n_cyc - t0 == 20, "divider ratio");
        conv(SACC_SRC_BUSY_WRITE, 1'b0, 1'b0, 1'b0, 5'h00, 6'h00, 10'h0F0);
        chk(t0 - n_cyc == 10, "divider zero");
        wr(8'h00, 8'hA0);
        @(posedge SYS_CLK);
        STANDBY <= 1'b1;
        IRQ_ENABLE <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        chk(TRACK_EN === 1'b0, "standby tracking");
        chk(CONV_DONE_IRQ === 1'b0, "interrupt while disabled");
        STANDBY <= 1'b0;
        IRQ_ENABLE <= 1'b1;
        wr(8'h04, 8'h08);
        chk(CONV_DONE_IRQ === 1'b1, "done interrupt");
        wr(8'h00, 8'h90);
        wr(8'h00, 8'h00);
        rdc(8'h00, 8'h00, 8'hFF);
        repeat (40) @(posedge SYS_CLK);
        chk(CONV_DONE_IRQ === 1'b0 && ADC_POWER_EN === 1'b0, "aborted conversion done");
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge SYS_CLK);
        n_errors++;
        report_and_stop();
    end
endmodule
